// >>> bench/alarm_lead_model.sv
`timescale 1ns/1ps
`default_nettype none

module alarm_lead_model (
  input wire logic clk_sys, // system clock
  input wire logic [14:0] cmd, // commanded lead levels
  output logic [7:0] ext_g1_in, // external g1 byte
  output logic [1:0] overhead_channel_input, // external o-bits
  output logic febe_nine_enable, // non-standard count enable
  output logic ring_rdi_input, // ring rdi port
  output logic ring_alarm_input, // ring alarm lead
  output logic path_alarm_input, // path alarm lead
  output logic ring_status_input // ring status lead
);
  // ----------------------------------------------------------------
  // leads move just after an edge, febe-nine enable follows cmd[4]
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    {ext_g1_in, overhead_channel_input, febe_nine_enable} <= cmd[14:4];
    {ring_rdi_input, ring_alarm_input, path_alarm_input, ring_status_input} <= cmd[3:0];
  end
endmodule : alarm_lead_model

`default_nettype wire

// >>> bench/test_tx_path_rdi_febe_obit_select.sv
`timescale 1ns/1ps
`default_nettype none

module test_tx_path_rdi_febe_obit_select;
  import tx_alarm_pkg::*;
  logic clk_sys, rst, ce, hsel, hwrite, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0] htrans, och, tx_overhead_bits;
  logic [31:0] hwdata, hrdata, r, ctrl, aux, g1r, obr, seed;
  logic [7:0] g1x, tx_g1;
  logic [3:0] b3;
  logic [7:0] al;
  logic [14:0] cmd;
  logic [11:0] exp_v;
  logic fen, rrdi, ralm, palm, rstat;
  int n_errors, check_count, cycles;

  alarm_lead_model partner (.clk_sys(clk_sys), .cmd(cmd), .ext_g1_in(g1x),
    .overhead_channel_input(och), .febe_nine_enable(fen), .ring_rdi_input(rrdi),
    .ring_alarm_input(ralm), .path_alarm_input(palm), .ring_status_input(rstat));

  tx_rdi_febe_obit_select dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .overhead_channel_input(och), .ext_g1_in(g1x), .ring_status_input(rstat),
    .path_alarm_input(palm), .ring_alarm_input(ralm), .ring_rdi_input(rrdi),
    .febe_nine_enable(fen), .e1_ais(al[0]), .e1_majority_ones(al[1]),
    .tug3_path_ais(al[2]), .loss_of_pointer(al[3]), .drop_j1_loss(al[4]),
    .drop_clock_loss(al[5]), .payload_label_mismatch(al[6]),
    .unequipped_label_alarm(al[7]), .b3_febe_count(b3), .tx_g1(tx_g1),
    .tx_overhead_bits(tx_overhead_bits));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      $display("MISMATCH timeout expected done seen hang");
      n_errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite single word transfer
  // ----------------------------------------------------------------
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
  endtask : bus

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0000_0000);
    chk(nm, e, r);
  endtask : rd

  task automatic check_reset();
    rd("ctrl reset", ADDR_TX_ALARM_CTRL, {24'h0, CTRL_RESET});
    rd("aux reset", ADDR_AUX_CTRL, {24'h0, AUX_RESET});
    rd("g1 ram reset", ADDR_G1_RAM, {24'h0, G1_RAM_RESET});
    rd("obit ram reset", ADDR_OBIT_RAM, {30'h0, OBIT_RESET});
    chk("g1 reset", {24'h0, G1_RAM_RESET}, {24'h0, tx_g1});
    chk("obits reset", {30'h0, OBIT_RESET}, {30'h0, tx_overhead_bits});
  endtask : check_reset

  // ----------------------------------------------------------------
  // reference model of the transmitted g1 byte and o-bits
  // ----------------------------------------------------------------
  function automatic logic [11:0] model();
    logic lead, f9, loc, rdi;
    logic [3:0] febe;
    lead = ctrl[3] ? (cmd[0] | cmd[1]) : al[0];
    f9 = ~aux[0] & cmd[4] & ((aux[2] & lead) | al[2] | al[3] | cmd[2]);
    loc = al[4] | al[5] | (aux[5] & (al[2] | al[3]));
    loc = loc | (ctrl[3] ? (cmd[0] | cmd[1]) : al[1]);
    loc = loc | (aux[3] & (al[6] | al[7]));
    rdi = ctrl[5] ? aux[4] : (aux[1] ? cmd[3] : loc);
    febe = f9 ? FEBE_NINE : (ctrl[4] ? b3 : g1r[7:4]);
    model[7:0] = aux[0] ? cmd[14:7] : {febe, rdi, g1r[2:0]};
    model[9:8] = ctrl[7] ? cmd[6:5] : obr[1:0];
    model[10] = f9;
    model[11] = loc;
  endfunction : model

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = '0;
    cmd = '0;
    al = '0;
    b3 = '0;
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    seed = $urandom(32'hae1a_e730);
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);

    check_reset();
    $display("test reset values done");

    for (int i = 0; i < 120; i++) begin
      cmd <= 15'($urandom);
      al <= 8'($urandom) & 8'($urandom);
      b3 <= 4'($urandom);
      ctrl = $urandom & {24'h0, CTRL_WR_MASK};
      aux = $urandom & 32'h0000_003f;
      if ($urandom % 4 != 0) aux[0] = 1'b0;
      g1r = $urandom & 32'h0000_00ff;
      obr = $urandom & 32'h0000_0003;
      bus(ADDR_TX_ALARM_CTRL, 1'b1, ctrl);
      bus(ADDR_AUX_CTRL, 1'b1, aux);
      bus(ADDR_G1_RAM, 1'b1, g1r);
      bus(ADDR_OBIT_RAM, 1'b1, obr);
      repeat (4) @(posedge clk_sys);
      exp_v = model();
      chk("tx_g1", {24'h0, exp_v[7:0]}, {24'h0, tx_g1});
      chk("tx_obits", {30'h0, exp_v[9:8]}, {30'h0, tx_overhead_bits});
      rd("status", ADDR_STATUS, {20'h0, exp_v});
      rd("ctrl", ADDR_TX_ALARM_CTRL, ctrl | {25'h0, cmd[4], 6'h0});
      rd("aux", ADDR_AUX_CTRL, aux);
    end
    $display("test random alarm selection done");

    // inputs move while the clock enable is low: outputs must hold
    exp_v = model();
    ce <= 1'b0;
    cmd <= ~cmd;
    al <= ~al;
    b3 <= ~b3;
    repeat (6) @(posedge clk_sys);
    chk("frozen tx_g1", {24'h0, exp_v[7:0]}, {24'h0, tx_g1});
    chk("frozen tx_obits", {30'h0, exp_v[9:8]}, {30'h0, tx_overhead_bits});
    ce <= 1'b1;
    repeat (6) @(posedge clk_sys);
    exp_v = model();
    chk("thawed tx_g1", {24'h0, exp_v[7:0]}, {24'h0, tx_g1});
    chk("thawed tx_obits", {30'h0, exp_v[9:8]}, {30'h0, tx_overhead_bits});
    $display("test clock enable freeze done");

    cmd <= '0;
    al <= '0;
    b3 <= '0;
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check_reset();
    ctrl = '0;
    aux = '0;
    g1r = '0;
    obr = '0;
    $display("test mid-run reset done");

    bus(12'h0d4, 1'b1, 32'hffff_ffff);
    rd("unmapped", 12'h0d4, 32'h0000_0000);
    $display("test unmapped access done");
    tally_and_finish();
  end
endmodule : test_tx_path_rdi_febe_obit_select

`default_nettype wire

// >>> core/tx_alarm_pkg.sv
package tx_alarm_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [11:0] ADDR_TX_ALARM_CTRL = 12'h0c4;
  localparam logic [11:0] ADDR_AUX_CTRL = 12'h0c8;
  localparam logic [11:0] ADDR_G1_RAM = 12'h0cc;
  localparam logic [11:0] ADDR_STATUS = 12'h0d0;
  localparam logic [11:0] ADDR_OBIT_RAM_INDEX = 12'h049;
  localparam logic [11:0] ADDR_OBIT_RAM = {ADDR_OBIT_RAM_INDEX[9:0], 2'b00};

  // ------------------------------------------------------------------
  // transmit_alarm_control fields
  // ------------------------------------------------------------------
  localparam int CTRL_EXT_OBIT = 7;
  localparam int CTRL_FEBE9_PIN = 6;
  localparam int CTRL_PROC_RDI = 5;
  localparam int CTRL_FEBE_EN = 4;
  localparam int CTRL_ALARM_LEAD = 3;
  localparam logic [7:0] CTRL_WR_MASK = 8'hbf;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ------------------------------------------------------------------
  // auxiliary control fields
  // ------------------------------------------------------------------
  localparam int AUX_EXT_G1 = 0;
  localparam int AUX_RING = 1;
  localparam int AUX_ALM_FEBE9 = 2;
  localparam int AUX_LABEL_AIS = 3;
  localparam int AUX_RDI_VALUE = 4;
  localparam int AUX_TUG3 = 5;
  localparam logic [7:0] AUX_RESET = 8'h00;

  // ------------------------------------------------------------------
  // g1 byte layout, status layout, other resets
  // ------------------------------------------------------------------
  localparam int G1_FEBE_HI = 7;
  localparam int G1_FEBE_LO = 4;
  localparam int G1_RDI = 3;
  localparam logic [3:0] FEBE_NINE = 4'h9;
  localparam logic [7:0] G1_RAM_RESET = 8'h00;
  localparam logic [1:0] OBIT_RESET = 2'h0;
  localparam int STAT_OBIT_LO = 8;
  localparam int STAT_FEBE9 = 10;
  localparam int STAT_LOCAL_RDI = 11;

  // ------------------------------------------------------------------
  // ahb-lite encodings
  // ------------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

endpackage : tx_alarm_pkg

// >>> core/tx_rdi_febe_obit_select.sv
`timescale 1ns/1ps
`default_nettype none

module tx_rdi_febe_obit_select
  import tx_alarm_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys, // 10 MHz system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic hsel, // ahb slave select
  input wire logic [ADDR_W-1:0] haddr, // ahb byte address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size, word only
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic hreadyout, // ahb slave ready
  output logic [31:0] hrdata, // ahb read data
  output logic hresp, // ahb response
  input wire logic [1:0] overhead_channel_input, // external O-bit pins
  input wire logic [7:0] ext_g1_in, // external overhead port G1 byte
  input wire logic ring_status_input, // ring status lead
  input wire logic path_alarm_input, // path alarm lead
  input wire logic ring_alarm_input, // ring alarm lead
  input wire logic ring_rdi_input, // external alarm indication port RDI
  input wire logic febe_nine_enable, // febe-nine enable lead
  input wire logic e1_ais, // AIS detected in received E1 byte
  input wire logic e1_majority_ones, // received E1 byte majority ones
  input wire logic tug3_path_ais, // TUG-3 path AIS alarm
  input wire logic loss_of_pointer, // loss of pointer alarm
  input wire logic drop_j1_loss, // drop bus loss of J1
  input wire logic drop_clock_loss, // drop bus loss of clock
  input wire logic payload_label_mismatch, // payload label mismatch
  input wire logic unequipped_label_alarm, // unequipped label alarm
  input wire logic [3:0] b3_febe_count, // normal B3 febe count
  output logic [7:0] tx_g1, // transmitted G1 byte
  output logic [1:0] tx_overhead_bits // transmitted O-bits
);

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  localparam int PIN_W = 15;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic [PIN_W-1:0] next_pin_s1;
  logic [PIN_W-1:0] next_pin_s2;

  assign pin_raw = {overhead_channel_input, ext_g1_in, ring_status_input,
                    path_alarm_input, ring_alarm_input, ring_rdi_input, febe_nine_enable};

  always_comb begin
    next_pin_s1 = pin_raw;
    next_pin_s2 = pin_s1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else if (ce) begin
      pin_s1 <= next_pin_s1;
      pin_s2 <= next_pin_s2;
    end
  end

  logic [1:0] ochan_s;
  logic [7:0] ext_g1_s;
  logic ring_status_s;
  logic path_alarm_s;
  logic ring_alarm_s;
  logic ring_rdi_s;
  logic febe9_pin_s;

  assign {ochan_s, ext_g1_s, ring_status_s, path_alarm_s, ring_alarm_s, ring_rdi_s,
          febe9_pin_s} = pin_s2;

  // ------------------------------------------------------------------
  // registers and ahb-lite slave
  // ------------------------------------------------------------------
  logic [7:0] ctrl;
  logic [7:0] aux;
  logic [7:0] g1_ram;
  logic [1:0] obit_ram;
  logic dp_valid;
  logic dp_write;
  logic [ADDR_W-1:0] dp_addr;
  logic [7:0] next_ctrl;
  logic [7:0] next_aux;
  logic [7:0] next_g1_ram;
  logic [1:0] next_obit_ram;
  logic next_dp_valid;
  logic next_dp_write;
  logic [ADDR_W-1:0] next_dp_addr;
  logic [31:0] next_hrdata;
  logic [31:0] status;
  logic addr_take;

  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                            input logic [7:0] c, input logic [7:0] x,
                                            input logic [7:0] g, input logic [1:0] o,
                                            input logic pin, input logic [31:0] st);
    logic [7:0] cv;
    cv = c;
    cv[CTRL_FEBE9_PIN] = pin;
    if (a == ADDR_TX_ALARM_CTRL) begin
      read_word = {24'h00_0000, cv};
    end else if (a == ADDR_AUX_CTRL) begin
      read_word = {24'h00_0000, x};
    end else if (a == ADDR_G1_RAM) begin
      read_word = {24'h00_0000, g};
    end else if (a == ADDR_OBIT_RAM) begin
      read_word = {30'h0000_0000, o};
    end else if (a == ADDR_STATUS) begin
      read_word = st;
    end else begin
      read_word = 32'h0000_0000;
    end
  endfunction : read_word

  assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);

  always_comb begin
    next_ctrl = ctrl;
    next_aux = aux;
    next_g1_ram = g1_ram;
    next_obit_ram = obit_ram;
    next_dp_valid = addr_take;
    next_dp_write = addr_take && hwrite;
    next_dp_addr = addr_take ? haddr : dp_addr;
    if (dp_valid && dp_write) begin
      if (dp_addr == ADDR_TX_ALARM_CTRL) begin
        next_ctrl = hwdata[7:0] & CTRL_WR_MASK;
      end else if (dp_addr == ADDR_AUX_CTRL) begin
        next_aux = hwdata[7:0];
      end else if (dp_addr == ADDR_G1_RAM) begin
        next_g1_ram = hwdata[7:0];
      end else if (dp_addr == ADDR_OBIT_RAM) begin
        next_obit_ram = hwdata[1:0];
      end
    end
    // read from next values so a read right after a write sees it
    next_hrdata = 32'h0000_0000;
    if (addr_take && !hwrite) begin
      next_hrdata = read_word(haddr, next_ctrl, next_aux, next_g1_ram, next_obit_ram,
                              febe9_pin_s, status);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
      aux <= AUX_RESET;
      g1_ram <= G1_RAM_RESET;
      obit_ram <= OBIT_RESET;
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= '0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end else if (ce) begin
      ctrl <= next_ctrl;
      aux <= next_aux;
      g1_ram <= next_g1_ram;
      obit_ram <= next_obit_ram;
      dp_valid <= next_dp_valid;
      dp_write <= next_dp_write;
      dp_addr <= next_dp_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end
  end

  // ------------------------------------------------------------------
  // febe nine, rdi and g1 / O-bit selection
  // ------------------------------------------------------------------
  logic ext_g1;
  logic alarm_src;
  logic febe9;
  logic local_rdi;
  logic rdi;
  logic [3:0] febe;
  logic [7:0] next_tx_g1;
  logic [1:0] next_tx_ob;

  always_comb begin
    ext_g1 = aux[AUX_EXT_G1];
    // alarm leads or E1 AIS drive alarm generation
    alarm_src = ctrl[CTRL_ALARM_LEAD] ? (ring_status_s | path_alarm_s) : e1_ais;
    febe9 = !ext_g1 && febe9_pin_s &&
            ((aux[AUX_ALM_FEBE9] && alarm_src) ||
             tug3_path_ais || loss_of_pointer ||
             ring_alarm_s);
    local_rdi = drop_j1_loss || drop_clock_loss ||
                (aux[AUX_TUG3] && (loss_of_pointer || tug3_path_ais)) ||
                (ctrl[CTRL_ALARM_LEAD] ? (ring_status_s | path_alarm_s)
                                       : e1_majority_ones) ||
                (aux[AUX_LABEL_AIS] && (payload_label_mismatch ||
                                        unequipped_label_alarm));
    if (ctrl[CTRL_PROC_RDI]) begin
      rdi = aux[AUX_RDI_VALUE];
    end else if (aux[AUX_RING]) begin
      rdi = ring_rdi_s;
    end else begin
      rdi = local_rdi;
    end
    if (febe9) begin
      febe = FEBE_NINE;
    end else if (ctrl[CTRL_FEBE_EN]) begin
      febe = b3_febe_count;
    end else begin
      febe = g1_ram[G1_FEBE_HI:G1_FEBE_LO];
    end
    if (ext_g1) begin
      next_tx_g1 = ext_g1_s;
    end else begin
      next_tx_g1 = {febe, rdi, g1_ram[G1_RDI-1:0]};
    end
    next_tx_ob = ctrl[CTRL_EXT_OBIT] ? ochan_s : obit_ram;
  end

  always_comb begin
    status = 32'h0000_0000;
    status[G1_FEBE_HI:0] = tx_g1;
    status[STAT_OBIT_LO+1:STAT_OBIT_LO] = tx_overhead_bits;
    status[STAT_FEBE9] = febe9;
    status[STAT_LOCAL_RDI] = local_rdi;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_g1 <= G1_RAM_RESET;
      tx_overhead_bits <= OBIT_RESET;
    end else if (ce) begin
      tx_g1 <= next_tx_g1;
      tx_overhead_bits <= next_tx_ob;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic local_mode;
  assign local_mode = !ext_g1 && !ctrl[CTRL_PROC_RDI] && !aux[AUX_RING];

  property p_ext_obit;
    ce && ctrl[CTRL_EXT_OBIT] |=> tx_overhead_bits == $past(ochan_s);
  endproperty
  a_ext_obit: assert property (p_ext_obit) else $error("O-bits not from pins");

  property p_ram_obit;
    ce && !ctrl[CTRL_EXT_OBIT] |=> tx_overhead_bits == $past(obit_ram);
  endproperty
  a_ram_obit: assert property (p_ram_obit) else $error("O-bits not from RAM");

  property p_febe9_leads;
    ce && !ext_g1 && febe9_pin_s && ctrl[CTRL_ALARM_LEAD] && aux[AUX_ALM_FEBE9] &&
    (ring_status_s || path_alarm_s) |=> tx_g1[G1_FEBE_HI:G1_FEBE_LO] == FEBE_NINE;
  endproperty
  a_febe9_leads: assert property (p_febe9_leads) else $error("no febe 9 on leads");

  property p_febe9_e1;
    ce && !ext_g1 && febe9_pin_s && !ctrl[CTRL_ALARM_LEAD] && aux[AUX_ALM_FEBE9] && e1_ais
    ##1 1'b1 |-> tx_g1[G1_FEBE_HI:G1_FEBE_LO] == FEBE_NINE;
  endproperty
  a_febe9_e1: assert property (p_febe9_e1) else $error("no febe 9 on E1 AIS");

  property p_febe9_tug3;
    ce && !ext_g1 && febe9_pin_s && (tug3_path_ais || loss_of_pointer)
    |=> tx_g1[G1_FEBE_HI:G1_FEBE_LO] == FEBE_NINE;
  endproperty
  a_febe9_tug3: assert property (p_febe9_tug3) else $error("no febe 9 on AIS/LOP");

  property p_febe9_ring;
    ce && !ext_g1 && febe9_pin_s && ring_alarm_s
    |=> tx_g1[G1_FEBE_HI:G1_FEBE_LO] == FEBE_NINE;
  endproperty
  a_febe9_ring: assert property (p_febe9_ring) else $error("no febe 9 on ring alarm");

  property p_no_febe9_pin_low;
    ce && !ext_g1 && !febe9_pin_s && !ctrl[CTRL_FEBE_EN]
    |=> tx_g1[G1_FEBE_HI:G1_FEBE_LO] == $past(g1_ram[G1_FEBE_HI:G1_FEBE_LO]);
  endproperty
  a_no_febe9_pin_low: assert property (p_no_febe9_pin_low) else $error("febe 9 while off");

  property p_rdi_drop;
    ce && local_mode && (drop_j1_loss || drop_clock_loss) |=> tx_g1[G1_RDI];
  endproperty
  a_rdi_drop: assert property (p_rdi_drop) else $error("no RDI on drop loss");

  property p_rdi_e1;
    ce && local_mode && !ctrl[CTRL_ALARM_LEAD] && e1_majority_ones |=> tx_g1[G1_RDI];
  endproperty
  a_rdi_e1: assert property (p_rdi_e1) else $error("no RDI on E1 ones");

  property p_rdi_label;
    ce && local_mode && aux[AUX_LABEL_AIS] && payload_label_mismatch |=> tx_g1[G1_RDI];
  endproperty
  a_rdi_label: assert property (p_rdi_label) else $error("no RDI on label alarm");

  property p_rdi_ring;
    ce && !ext_g1 && !ctrl[CTRL_PROC_RDI] && aux[AUX_RING]
    |=> tx_g1[G1_RDI] == $past(ring_rdi_s);
  endproperty
  a_rdi_ring: assert property (p_rdi_ring) else $error("RDI not from alarm port");

  property p_rdi_proc;
    ce && !ext_g1 && ctrl[CTRL_PROC_RDI] |=> tx_g1[G1_RDI] == $past(aux[AUX_RDI_VALUE]);
  endproperty
  a_rdi_proc: assert property (p_rdi_proc) else $error("RDI not from processor");

  property p_ext_g1;
    ce && ext_g1 |=> tx_g1 == $past(ext_g1_s);
  endproperty
  a_ext_g1: assert property (p_ext_g1) else $error("G1 not from port");

  property p_freeze;
    !ce |=> $stable(tx_g1) && $stable(tx_overhead_bits) && $stable(ctrl);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with ce low");

  c_febe9: cover property (ce && febe9 ##1 tx_g1[G1_FEBE_HI:G1_FEBE_LO] == FEBE_NINE);
  c_ring: cover property (ce && aux[AUX_RING] && ring_rdi_s ##1 tx_g1[G1_RDI]);
  c_ext_g1: cover property (ce && ext_g1 ##1 tx_g1 == $past(ext_g1_s));
  c_write: cover property (ce && dp_valid && dp_write && dp_addr == ADDR_TX_ALARM_CTRL);

endmodule : tx_rdi_febe_obit_select

`default_nettype wire
